// ### hw/arh_pkg.sv
package arh_pkg;

    localparam int unsigned W_BUS = 16;
    localparam int unsigned W_WORD = 32;
    localparam int unsigned FIFO_AW = 5;
    localparam int unsigned LBL_N = 16;

    // Configuration word bit positions
    localparam int unsigned CFG_RX1_RATE = 0;
    localparam int unsigned CFG_LBL_MODE = 1;
    localparam int unsigned CFG_RX1_FILT = 2;
    localparam int unsigned CFG_RX2_FILT = 3;
    localparam int unsigned CFG_PAR_EN = 4;
    localparam int unsigned CFG_LOOP_N = 5;
    localparam int unsigned CFG_RX1_DEC = 6;
    localparam int unsigned CFG_RX1_M9 = 7;
    localparam int unsigned CFG_RX2_DEC = 9;
    localparam int unsigned CFG_RX2_M9 = 10;
    localparam int unsigned CFG_PAR_INV = 12;
    localparam int unsigned CFG_TX_RATE = 13;
    localparam int unsigned CFG_RX2_RATE = 14;
    localparam int unsigned CFG_ORDER = 15;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Flag word bit positions
    localparam int unsigned SR_RX1_HAS = 0;
    localparam int unsigned SR_RX2_HAS = 3;
    localparam int unsigned SR_TX_EMPTY = 6;
    localparam int unsigned SR_TX_FULL = 7;
    localparam int unsigned SR_TX_HALF = 8;

    localparam logic [5:0] FIFO_DEPTH = 6'h20;
    localparam logic [5:0] FIFO_HALF = 6'h10;
    localparam logic [4:0] LBL_DONE = 5'h10;
    localparam logic [6:0] DIV_FAST = 7'h0A;
    localparam logic [6:0] DIV_SLOW = 7'h50;
    localparam logic [4:0] PREV_IDLE = 5'h1F;

    // Strobe history positions
    localparam int unsigned PV_CWS = 0;
    localparam int unsigned PV_EN1 = 1;
    localparam int unsigned PV_EN2 = 2;
    localparam int unsigned PV_PL1 = 3;
    localparam int unsigned PV_PL2 = 4;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } arh_rx_word_s;

    typedef struct packed {
        logic [15:0] cfg;
        logic [1:0][15:0][7:0] lbl;
        logic [1:0][4:0] lwcnt;
        logic [1:0][3:0] lridx;
        logic [2:0][4:0] wp;
        logic [2:0][4:0] rp;
        logic [2:0][5:0] cnt;
        logic [15:0] hold;
        logic [4:0] prev;
        logic [15:0] rd_data;
        logic tx_ready;
        logic [2:0][6:0] div;
        logic [2:0] tick;
    } arh_state_s;

    // Word (bit n of the serial word at index n-1) to {second half, first half}
    function automatic logic [31:0] arh_to_bus(input logic [31:0] w, input logic unscr);
        logic [15:0] h1;
        h1 = '0;
        if (unscr) begin
            return w;
        end
        for (int i = 0; i < 8; i++) begin
            h1[7 - i] = w[i];
        end
        h1[15:11] = {w[12], w[11], w[10], w[9], w[8]};
        h1[10:8] = {w[30], w[29], w[31]};
        return {w[28:13], h1};
    endfunction

    function automatic logic [31:0] arh_from_bus(input logic [31:0] b, input logic unscr);
        logic [31:0] w;
        w = b;
        if (!unscr) begin
            for (int i = 0; i < 8; i++) begin
                w[i] = b[7 - i];
            end
            w[12:8] = b[15:11];
            w[30] = b[10];
            w[29] = b[9];
            w[31] = b[8];
            w[28:13] = b[31:16];
        end
        return w;
    endfunction

endpackage

// ### hw/arh_fifo_mem.sv
module arh_fifo_mem
    import arh_pkg::*;
#(
    parameter int unsigned W = 32,
    parameter int unsigned AW = 5
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);

    logic [W-1:0] mem [0:(1 << AW) - 1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ### hw/arh_ctrl_status.sv
// What this block does
// - Config write strobe low loads all sixteen bus lines into configuration word.
// - Register read strobe low with select high puts configuration word on bus.
// - Register read strobe low with select low puts nine flags, upper lines zero.
// - Each receiver rate bit selects clock divided by 10 or 80.
// - Transmit rate bit selects divide 10 fast slope or divide 80 slow slope.
// - Transmit bit clock output is clock divided by 10 or 80.
// - Label mode: load strobes write, read enables read sixteen labels per receiver.
// - Per-receiver bit enables label filtering of received words.
// - Parity enable puts parity in bit 32, else host data stays.
// - Parity invert bit clear gives odd parity, set gives even.
// - Self-test bit zero loops transmitter line outputs into receiver inputs.
// - Receiver 1 decoder accepts only words whose bits 9,10 match its bits.
// - Receiver 2 decoder accepts only words whose bits 9,10 match its bits.
// - Data-format bit picks scrambled or straight bus ordering, reads and writes.
// - Has-data flag set while receive FIFO non-empty; ready pin is inverse.
// - Receive half-full flag at sixteen or more words; pin is inverse.
// - Receive full flag and inverse pin; host must drain within one word.
// - Transmit FIFO reports empty, full, half-full; full and half-full on pins.
// - Transmit ready drops on load, rises when sent and FIFO empty.
// - Select low first half, high second; enable 2 only while enable 1 high.
// - Three 32-word by 32-bit FIFOs: two receive, one transmit.
// - Label mode entry: next sixteen loads fill labels; reception pauses meanwhile.
// - Full receive FIFO: next accepted word overwrites last location.
module arh_ctrl_status
    import arh_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] host_bus_in,
    output logic [15:0] host_bus_out,
    output logic host_bus_oe,
    input wire logic config_write_strobe_n,
    input wire logic register_read_strobe_n,
    input wire logic half_sel,
    input wire logic rx1_read_enable_n,
    input wire logic rx2_read_enable_n,
    input wire logic tx_first_half_latch_n,
    input wire logic tx_second_half_latch_n,
    input wire logic tx_go,
    input wire arh_rx_word_s rx1_word,
    input wire arh_rx_word_s rx2_word,
    input wire logic [1:0] rx1_line_in,
    input wire logic [1:0] rx2_line_in,
    input wire logic [1:0] tx_ser_line,
    input wire logic tx_word_take,
    input wire logic tx_busy,
    output logic [1:0] rx1_line_to_logic,
    output logic [1:0] rx2_line_to_logic,
    output logic [1:0] tx_line_out,
    output logic [31:0] tx_word_data,
    output logic tx_word_avail,
    output logic [1:0] rx_bit_tick,
    output logic tx_bit_clk,
    output logic tx_slope_slow,
    output logic [8:0] fifo_flag_word,
    output logic rx1_ready_n,
    output logic rx1_half_full_n,
    output logic rx1_full_n,
    output logic rx2_ready_n,
    output logic rx2_half_full_n,
    output logic rx2_full_n,
    output logic tx_half_full_n,
    output logic tx_full_n,
    output logic tx_ready
);

    arh_state_s q;
    arh_state_s s;
    logic [2:0] mem_we;
    logic [2:0][4:0] mem_wa;
    logic [2:0][31:0] mem_wd;
    logic [2:0][31:0] mem_rd;
    logic [2:0][4:0] mem_ra;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_fifo
            arh_fifo_mem #(.W(W_WORD), .AW(FIFO_AW)) u_mem (
                .clk(clk),
                .resetn(resetn),
                .wr_en(mem_we[g]),
                .wr_addr(mem_wa[g]),
                .wr_data(mem_wd[g]),
                .rd_addr(mem_ra[g]),
                .rd_data(mem_rd[g])
            );
        end
    endgenerate

    logic [2:0] full;
    logic [2:0] half;
    logic [2:0] has;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            full[i] = (q.cnt[i] == FIFO_DEPTH);
            half[i] = (q.cnt[i] >= FIFO_HALF);
            has[i] = (q.cnt[i] != 6'h00);
        end
    end

    // Flag word and pins
    assign fifo_flag_word = {half[2], full[2], ~has[2], full[1], half[1], has[1],
                             full[0], half[0], has[0]};
    assign rx1_ready_n = ~has[0];
    assign rx2_ready_n = ~has[1];
    assign rx1_half_full_n = ~half[0];
    assign rx2_half_full_n = ~half[1];
    assign rx1_full_n = ~full[0];
    assign rx2_full_n = ~full[1];
    assign tx_half_full_n = ~half[2];
    assign tx_full_n = ~full[2];
    assign tx_ready = q.tx_ready;

    // Self-test loop routes the serializer outputs back into both receivers
    assign rx1_line_to_logic = q.cfg[CFG_LOOP_N] ? rx1_line_in : tx_ser_line;
    assign rx2_line_to_logic = q.cfg[CFG_LOOP_N] ? rx2_line_in : tx_ser_line;
    assign tx_line_out = tx_ser_line;

    assign tx_word_data = mem_rd[2];
    assign tx_word_avail = tx_go & has[2];
    assign rx_bit_tick = q.tick[1:0];
    assign tx_bit_clk = q.tick[2];
    assign tx_slope_slow = q.cfg[CFG_TX_RATE];

    assign host_bus_out = q.rd_data;
    assign host_bus_oe = ~register_read_strobe_n | ~rx1_read_enable_n |
                         ~rx2_read_enable_n;

    logic [4:0] now;
    assign now = {tx_second_half_latch_n, tx_first_half_latch_n, rx2_read_enable_n,
                  rx1_read_enable_n, config_write_strobe_n};

    always_comb begin
        logic [4:0] fall;
        logic [4:0] rise;
        logic lmode;
        logic loading;
        logic [1:0] ack;
        logic [1:0] rd_end;
        logic [2:0] push;
        logic [2:0] pop;
        logic [2:0] rsel;
        logic [6:0] lim;
        logic [31:0] w;
        logic [31:0] b;
        logic [1:0] filt;
        logic [1:0] dec;
        logic [1:0][1:0] match;
        logic hit;
        arh_rx_word_s rxw [2];
        s = q;
        fall = q.prev & ~now;
        rise = ~q.prev & now;
        lmode = q.cfg[CFG_LBL_MODE];
        loading = lmode && ((q.lwcnt[0] != LBL_DONE) || (q.lwcnt[1] != LBL_DONE));
        rd_end[0] = rise[PV_EN1];
        rd_end[1] = rise[PV_EN2] & rx1_read_enable_n;
        lim = DIV_FAST;
        ack = '0;
        push = '0;
        pop = '0;
        w = '0;
        b = '0;
        hit = 1'b0;
        mem_we = '0;
        mem_wa = '0;
        mem_wd = '0;
        rxw[0] = rx1_word;
        rxw[1] = rx2_word;
        filt = {q.cfg[CFG_RX2_FILT], q.cfg[CFG_RX1_FILT]};
        dec = {q.cfg[CFG_RX2_DEC], q.cfg[CFG_RX1_DEC]};
        match[0] = q.cfg[CFG_RX1_M9 +: 2];
        match[1] = q.cfg[CFG_RX2_M9 +: 2];
        rsel = {q.cfg[CFG_TX_RATE], q.cfg[CFG_RX2_RATE], q.cfg[CFG_RX1_RATE]};
        s.prev = now;

        // Configuration write; rising label-mode bit restarts label loading
        if (fall[PV_CWS]) begin
            s.cfg = host_bus_in;
            if (!q.cfg[CFG_LBL_MODE] && host_bus_in[CFG_LBL_MODE]) begin
                s.lwcnt = '0;
                s.lridx = '0;
            end
        end

        // Read data path, register strobe first, then receiver 1, then 2
        ack[0] = ~rx1_read_enable_n;
        ack[1] = ~rx2_read_enable_n & rx1_read_enable_n;
        if (!register_read_strobe_n) begin
            s.rd_data = half_sel ? q.cfg : {7'h00, fifo_flag_word};
        end else if (ack[0] || ack[1]) begin
            for (int c = 0; c < 2; c++) begin
                if (ack[c]) begin
                    b = arh_to_bus(mem_rd[c], q.cfg[CFG_ORDER]);
                    if (lmode) begin
                        s.rd_data = {8'h00, q.lbl[c][q.lridx[c]]};
                    end else begin
                        s.rd_data = half_sel ? b[31:16] : b[15:0];
                    end
                end
            end
        end else begin
            s.rd_data = '0;
        end

        // End of a read strobe: advance label index or pop after second half
        for (int c = 0; c < 2; c++) begin
            if (rd_end[c]) begin
                if (lmode) begin
                    s.lridx[c] = q.lridx[c] + 4'h1;
                end else if (half_sel && has[c]) begin
                    pop[c] = 1'b1;
                end
            end
        end

        // Receive path: filter, decode, store or overwrite the last word
        for (int c = 0; c < 2; c++) begin
            hit = 1'b0;
            for (int j = 0; j < LBL_N; j++) begin
                if (q.lbl[c][j] == rxw[c].data[7:0]) begin
                    hit = 1'b1;
                end
            end
            if (rxw[c].valid && !loading && (!filt[c] || hit) &&
                (!dec[c] || (rxw[c].data[9:8] == match[c]))) begin
                mem_we[c] = 1'b1;
                mem_wd[c] = rxw[c].data;
                if (full[c] && !pop[c]) begin
                    mem_wa[c] = q.wp[c] - 5'h01;
                end else begin
                    mem_wa[c] = q.wp[c];
                    push[c] = 1'b1;
                end
            end
        end

        // Load strobes: labels in label mode, else the two transmit halves
        if (fall[PV_PL1]) begin
            if (lmode) begin
                if (q.lwcnt[0] != LBL_DONE) begin
                    s.lbl[0][q.lwcnt[0][3:0]] = host_bus_in[7:0];
                    s.lwcnt[0] = q.lwcnt[0] + 5'h01;
                end
            end else begin
                s.hold = host_bus_in;
            end
        end
        if (fall[PV_PL2]) begin
            if (lmode) begin
                if (q.lwcnt[1] != LBL_DONE) begin
                    s.lbl[1][q.lwcnt[1][3:0]] = host_bus_in[7:0];
                    s.lwcnt[1] = q.lwcnt[1] + 5'h01;
                end
            end else if (!full[2]) begin
                w = arh_from_bus({host_bus_in, q.hold}, q.cfg[CFG_ORDER]);
                if (q.cfg[CFG_PAR_EN]) begin
                    w[31] = q.cfg[CFG_PAR_INV] ? ^w[30:0] : ~^w[30:0];
                end
                mem_we[2] = 1'b1;
                mem_wa[2] = q.wp[2];
                mem_wd[2] = w;
                push[2] = 1'b1;
            end
        end
        pop[2] = tx_word_take & has[2];

        // Transmit ready: a load wins over the empty-and-idle release
        if (push[2]) begin
            s.tx_ready = 1'b0;
        end else if (!has[2] && !tx_busy) begin
            s.tx_ready = 1'b1;
        end

        // Pointer and count update; read address runs one cycle ahead
        for (int i = 0; i < 3; i++) begin
            if (push[i]) begin
                s.wp[i] = q.wp[i] + 5'h01;
            end
            if (pop[i]) begin
                s.rp[i] = q.rp[i] + 5'h01;
            end
            case ({push[i], pop[i]})
                2'b10: s.cnt[i] = q.cnt[i] + 6'h01;
                2'b01: s.cnt[i] = q.cnt[i] - 6'h01;
                default: s.cnt[i] = q.cnt[i];
            endcase
            mem_ra[i] = s.rp[i];
        end

        // Rate dividers: receiver ticks pulse, transmit clock is a level
        for (int i = 0; i < 3; i++) begin
            lim = rsel[i] ? DIV_SLOW : DIV_FAST;
            if (q.div[i] >= lim - 7'h01) begin
                s.div[i] = '0;
            end else begin
                s.div[i] = q.div[i] + 7'h01;
            end
            if (i == 2) begin
                s.tick[i] = (s.div[i] < (lim >> 1));
            end else begin
                s.tick[i] = (s.div[i] == '0);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.cfg <= CFG_RESET;
            q.prev <= PREV_IDLE;
            q.tx_ready <= 1'b1;
        end else begin
            q <= s;
        end
    end

endmodule

// ### test/arh_ctrl_status_monitor.sv
module arh_ctrl_status_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] host_bus_in,
    input wire logic [15:0] host_bus_out,
    input wire logic host_bus_oe,
    input wire logic config_write_strobe_n,
    input wire logic register_read_strobe_n,
    input wire logic half_sel,
    input wire logic tx_second_half_latch_n,
    input wire logic [1:0] rx1_line_in,
    input wire logic [1:0] tx_ser_line,
    input wire logic [1:0] rx1_line_to_logic,
    input wire logic [1:0] tx_line_out,
    input wire logic tx_bit_clk,
    input wire logic tx_slope_slow,
    input wire logic [8:0] fifo_flag_word,
    input wire logic rx1_ready_n,
    input wire logic rx1_half_full_n,
    input wire logic rx1_full_n,
    input wire logic rx2_ready_n,
    input wire logic rx2_half_full_n,
    input wire logic rx2_full_n,
    input wire logic tx_half_full_n,
    input wire logic tx_full_n,
    input wire logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cws_q;
    logic tbc_q;
    logic [15:0] cfg_q;
    logic [7:0] per_q;
    logic [1:0] seen_q;
    // Shadow of the configuration word and the bit clock period
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cws_q <= 1'b1;
            tbc_q <= 1'b0;
            cfg_q <= 16'h0000;
            per_q <= 8'h00;
            seen_q <= 2'h0;
        end else begin
            cws_q <= config_write_strobe_n;
            tbc_q <= tx_bit_clk;
            per_q <= (tx_bit_clk && !tbc_q) ? 8'h01 : per_q + {7'h00, per_q != 8'hFF};
            if (cws_q && !config_write_strobe_n) begin
                cfg_q <= host_bus_in;
                seen_q <= 2'h0;
            end else if (tx_bit_clk && !tbc_q && seen_q != 2'h2) begin
                seen_q <= seen_q + 2'h1;
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    cfg_readback_a: assert property (
        (!register_read_strobe_n && half_sel) [*2] |-> host_bus_out == cfg_q)
        else $error("config readback differs");
    status_read_a: assert property (
        (!register_read_strobe_n && !half_sel) [*2] |->
        host_bus_out == {7'h00, $past(fifo_flag_word)}) else $error("status read differs");
    oe_read_a: assert property (!register_read_strobe_n |-> host_bus_oe)
        else $error("bus not driven on read");
    slope_sel_a: assert property (tx_slope_slow == cfg_q[13])
        else $error("slope select differs");
    loop_route_a: assert property (
        rx1_line_to_logic == (cfg_q[5] ? rx1_line_in : tx_ser_line) &&
        tx_line_out == tx_ser_line)
        else $error("line routing differs");
    rx_pins_a: assert property (
        {rx2_full_n, rx2_half_full_n, rx2_ready_n, rx1_full_n, rx1_half_full_n, rx1_ready_n} ==
        ~fifo_flag_word[5:0])
        else $error("receive pins differ");
    tx_pins_a: assert property ({tx_half_full_n, tx_full_n} == ~fifo_flag_word[8:7])
        else $error("transmit pins differ");
    flag_nest_a: assert property (fifo_flag_word[2] |-> fifo_flag_word[1:0] == 2'h3)
        else $error("full without half");
    tx_load_a: assert property (
        $fell(tx_second_half_latch_n) && !fifo_flag_word[7] && !cfg_q[1] |=>
        !tx_ready && !fifo_flag_word[6]) else $error("load not flagged");
    bit_period_a: assert property (
        tx_bit_clk && !tbc_q && seen_q == 2'h2 |-> per_q == (cfg_q[13] ? 8'h50 : 8'h0A))
        else $error("bit clock period wrong");
    reset_empty_a: assert property (
        @(posedge clk) disable iff (1'b0) !resetn |->
        fifo_flag_word == 9'h040 && tx_ready && host_bus_out == 16'h0000)
        else $error("reset state wrong");
    cover property ((!register_read_strobe_n && half_sel) [*2]);
    cover property (fifo_flag_word[2]);
    cover property ($fell(tx_second_half_latch_n));
endmodule
bind arh_ctrl_status arh_ctrl_status_monitor mon (.clk, .resetn, .host_bus_in, .host_bus_out,
    .host_bus_oe, .config_write_strobe_n, .register_read_strobe_n, .half_sel,
    .tx_second_half_latch_n, .rx1_line_in, .tx_ser_line, .rx1_line_to_logic, .tx_line_out,
    .tx_bit_clk, .tx_slope_slow, .fifo_flag_word, .rx1_ready_n, .rx1_half_full_n,
    .rx1_full_n, .rx2_ready_n, .rx2_half_full_n, .rx2_full_n, .tx_half_full_n, .tx_full_n,
    .tx_ready);

// ### test/arh_host_model.sv
module arh_host_model (
    input wire logic clk,
    input wire logic [15:0] bus_rd,
    output logic [15:0] bus_wr,
    output logic cws_n,
    output logic rrs_n,
    output logic sel,
    output logic en1_n,
    output logic en2_n,
    output logic pl1_n,
    output logic pl2_n,
    output logic go
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bus_wr = 16'hFFFF;
        {cws_n, rrs_n, en1_n, en2_n, pl1_n, pl2_n} = 6'h3F;
        {sel, go} = 2'h0;
    end
    task automatic cfg_wr(input logic [15:0] d);
        @(negedge clk);
        bus_wr = d;
        cws_n = 1'b0;
        @(negedge clk);
        cws_n = 1'b1;
        bus_wr = ~d;
        @(negedge clk);
    endtask
    task automatic reg_rd(input logic s, output logic [15:0] d);
        @(negedge clk);
        sel = s;
        rrs_n = 1'b0;
        repeat (2) @(negedge clk);
        d = bus_rd;
        rrs_n = 1'b1;
        @(negedge clk);
    endtask
    // First half with select low, second with select high
    task automatic rx_rd(input logic r2, output logic [31:0] d);
        for (int h = 0; h < 2; h++) begin
            @(negedge clk);
            sel = h[0];
            en1_n = r2;
            en2_n = !r2;
            repeat (2) @(negedge clk);
            d[16*h +: 16] = bus_rd;
            {en1_n, en2_n} = 2'h3;
            repeat (2) @(negedge clk);
        end
    endtask
    task automatic tx_ld(input logic [15:0] lo, input logic [15:0] hi);
        @(negedge clk);
        bus_wr = lo;
        pl1_n = 1'b0;
        @(negedge clk);
        pl1_n = 1'b1;
        @(negedge clk);
        bus_wr = hi;
        pl2_n = 1'b0;
        @(negedge clk);
        pl2_n = 1'b1;
        bus_wr = ~hi;
        @(negedge clk);
    endtask
endmodule

// ### test/test_arh_ctrl_status.sv
module test_arh_ctrl_status import arh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [15:0] cfg;
        logic slope;
        logic [1:0] line;
    } arh_row_s;
    localparam arh_row_s ROWS [4] = '{'{16'h0000, 1'b0, 2'h2}, '{16'hFFFD, 1'b1, 2'h1},
        '{16'hA5A5, 1'b1, 2'h1}, '{16'h2000, 1'b1, 2'h2}};
    logic clk = 1'b0, resetn = 1'b1, tx_word_take = 1'b0, tx_busy = 1'b0;
    logic [1:0] rx1_line_in = 2'h1, rx2_line_in = 2'h1, tx_ser_line = 2'h2;
    arh_rx_word_s rx1_word = '0, rx2_word = '0;
    logic [15:0] host_bus_in, host_bus_out, v;
    logic config_write_strobe_n, register_read_strobe_n, half_sel, tx_go, tx_word_avail;
    logic rx1_read_enable_n, rx2_read_enable_n, tx_first_half_latch_n, tx_second_half_latch_n;
    logic tx_bit_clk, tx_slope_slow, tx_ready, tx_half_full_n, tx_full_n;
    logic [1:0] rx1_line_to_logic, tx_line_out, rx_bit_tick;
    logic [31:0] tx_word_data, w;
    logic [8:0] fifo_flag_word;
    logic rx1_ready_n, rx1_half_full_n, rx1_full_n, rx2_ready_n, rx2_half_full_n, rx2_full_n;
    int failures = 0, total_checks = 0, cycles = 0, n;
    wire [2:0] sig = {rx_bit_tick, tx_bit_clk};
    always #20 clk = ~clk;
    arh_host_model host (.clk, .bus_rd(host_bus_out), .bus_wr(host_bus_in),
        .cws_n(config_write_strobe_n), .rrs_n(register_read_strobe_n), .sel(half_sel),
        .en1_n(rx1_read_enable_n), .en2_n(rx2_read_enable_n), .pl1_n(tx_first_half_latch_n),
        .pl2_n(tx_second_half_latch_n), .go(tx_go));
    arh_ctrl_status dut (.clk, .resetn, .host_bus_in, .host_bus_out, .host_bus_oe(),
        .config_write_strobe_n, .register_read_strobe_n, .half_sel, .rx1_read_enable_n,
        .rx2_read_enable_n, .tx_first_half_latch_n, .tx_second_half_latch_n, .tx_go,
        .rx1_word, .rx2_word, .rx1_line_in, .rx2_line_in, .tx_ser_line, .tx_word_take,
        .tx_busy, .rx1_line_to_logic, .rx2_line_to_logic(), .tx_line_out, .tx_word_data,
        .tx_word_avail, .rx_bit_tick, .tx_bit_clk, .tx_slope_slow, .fifo_flag_word,
        .rx1_ready_n, .rx1_half_full_n, .rx1_full_n, .rx2_ready_n, .rx2_half_full_n,
        .rx2_full_n, .tx_half_full_n, .tx_full_n, .tx_ready);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            results();
        end
    end
    task automatic tx_pop();
        @(negedge clk);
        tx_word_take = 1'b1;
        @(negedge clk);
        tx_word_take = 1'b0;
    endtask
    task automatic push(input logic r2, input logic [31:0] d);
        @(negedge clk);
        if (r2) rx2_word = {1'b1, d};
        else rx1_word = {1'b1, d};
        @(negedge clk);
        rx1_word = {1'b0, ~rx1_word.data};
        rx2_word = {1'b0, ~rx2_word.data};
    endtask
    // Cycles between the second and third rise of the chosen pulse
    task automatic period(input int k, output int c);
        logic p;
        int r;
        p = 1'b1;
        r = 0;
        c = 0;
        while (r < 3) begin
            @(negedge clk);
            c++;
            if (sig[k] && !p) begin
                r++;
                if (r < 3) c = 0;
            end
            p = sig[k];
        end
    endtask
    initial begin
        #1 resetn = 1'b0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        chk("flags", fifo_flag_word, 9'h040);
        chk("pins", {rx1_ready_n, rx2_ready_n, rx1_full_n, tx_full_n, tx_ready}, 5'h1F);
        host.reg_rd(1'b0, v);
        chk("status", v, 16'h0040);
        foreach (ROWS[i]) begin
            host.cfg_wr(ROWS[i].cfg);
            host.reg_rd(1'b1, v);
            chk("cfg", v, ROWS[i].cfg);
            chk("slope", tx_slope_slow, ROWS[i].slope);
            chk("loop", rx1_line_to_logic, ROWS[i].line);
        end
        for (int c = 0; c < 2; c++) begin
            host.cfg_wr(c ? 16'h6001 : 16'h0000);
            for (int k = 0; k < 3; k++) begin
                period(k, n);
                chk("period", n, c ? 80 : 10);
            end
        end
        host.cfg_wr(16'h8010);
        host.go = 1'b1;
        host.tx_ld(16'h1234, 16'h8000);
        @(negedge clk);
        chk("txword", tx_word_data, 32'h00001234);
        chk("txstat", {fifo_flag_word[6], tx_ready, tx_word_avail}, 3'h1);
        tx_busy = 1'b1;
        tx_pop();
        repeat (2) @(negedge clk);
        chk("txbusy", tx_ready, 1'b0);
        host.cfg_wr(16'h9010);
        host.tx_ld(16'h1234, 16'h0000);
        @(negedge clk);
        chk("txword", tx_word_data, 32'h80001234);
        tx_pop();
        tx_busy = 1'b0;
        repeat (3) @(negedge clk);
        chk("txdone", {fifo_flag_word[6], tx_ready}, 2'h3);
        for (int i = 0; i < 33; i++) begin
            host.tx_ld(i[15:0], 16'h0000);
            if (i == 15) chk("txhalf", {fifo_flag_word[8], tx_half_full_n}, 2'h2);
        end
        chk("txfull", {fifo_flag_word[7], tx_full_n}, 2'h2);
        repeat (32) tx_pop();
        @(negedge clk);
        chk("txempty", fifo_flag_word[8:6], 3'h1);
        host.cfg_wr(16'h8020);
        for (int i = 0; i < 33; i++) begin
            push(1'b0, 32'h5A000000 | i);
            if (i == 0) chk("rxhas", {fifo_flag_word[0], rx1_ready_n}, 2'h2);
            if (i == 15) chk("rxhalf", {fifo_flag_word[1], rx1_half_full_n}, 2'h2);
            if (i == 31) chk("rxfull", {fifo_flag_word[2], rx1_full_n}, 2'h2);
        end
        for (int i = 0; i < 32; i++) begin
            host.rx_rd(1'b0, w);
            chk("rxword", w, 32'h5A000000 | (i == 31 ? 32 : i));
        end
        chk("rxempty", {fifo_flag_word[0], rx1_ready_n}, 2'h1);
        host.cfg_wr(16'h0020);
        push(1'b1, 32'h80002101);
        host.rx_rd(1'b1, w);
        chk("scramble", w, 32'h00010980);
        host.cfg_wr(16'h80E4);
        push(1'b0, 32'h00000105);
        push(1'b0, 32'h00000200);
        push(1'b0, 32'h00000100);
        host.rx_rd(1'b0, w);
        chk("filter", w, 32'h00000100);
        chk("filtcnt", fifo_flag_word[0], 1'b0);
        host.cfg_wr(16'h0002);
        for (int i = 0; i < 16; i++) host.tx_ld(i[15:0], 16'h0040 + i[15:0]);
        host.rx_rd(1'b1, w);
        chk("label", w, 32'h00410040);
        host.cfg_wr(16'h0600);
        push(1'b1, 32'h00000200);
        push(1'b1, 32'h00000100);
        host.rx_rd(1'b1, w);
        chk("dec2", w, 32'h00000800);
        chk("dec2cnt", fifo_flag_word[3], 1'b0);
        results();
    end
endmodule
